// File: hdl/efa_pkg.sv
// package: register map, fields, timing constants and carriers for echo filter adaptation
package efa_pkg;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_SAWTOOTH  = 12'h1C0;
  localparam logic [11:0] OFF_DAMPING   = 12'h1C4;
  localparam logic [11:0] OFF_TAIL      = 12'h1C8;
  localparam logic [11:0] OFF_WINDOWS   = 12'h1CC;
  localparam logic [11:0] OFF_HANG_GAP  = 12'h1D0;
  localparam logic [11:0] OFF_PRESET    = 12'h1D4;
  localparam logic [11:0] OFF_TURBO     = 12'h1DC;
  localparam logic [11:0] OFF_AUXSUP    = 12'h1E0;
  localparam logic [11:0] OFF_CTRL      = 12'h1E4;
  localparam logic [11:0] OFF_STATUS    = 12'h1E8;
  // printed register indices; byte address is four times these
  localparam logic [7:0]  IDX_SAWTOOTH  = 8'h70;
  localparam logic [7:0]  IDX_DAMPING   = 8'h71;
  localparam logic [7:0]  IDX_TAIL      = 8'h72;
  localparam logic [7:0]  IDX_WINDOWS   = 8'h73;
  localparam logic [7:0]  IDX_HANG_GAP  = 8'h74;
  localparam logic [7:0]  IDX_PRESET    = 8'h75;
  localparam logic [7:0]  IDX_TURBO     = 8'h77;
  localparam logic [7:0]  IDX_AUXSUP    = 8'h78;
  // ----------------------------------------------------------------
  // reset values and write masks
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_SAWTOOTH  = 8'h00;
  localparam logic [7:0]  RST_DAMPING   = 8'h44;
  localparam logic [7:0]  RST_TAIL      = 8'h0F;
  localparam logic [7:0]  RST_WINDOWS   = 8'h77;
  localparam logic [7:0]  RST_HANG_GAP  = 8'h74;
  localparam logic [7:0]  RST_PRESET    = 8'h85;
  localparam logic [7:0]  RST_TURBO     = 8'h08;
  localparam logic [7:0]  RST_AUXSUP    = 8'h00;
  localparam logic [7:0]  RST_CTRL      = 8'h00;
  localparam logic [7:0]  MSK_DAMPING   = 8'h77;
  localparam logic [7:0]  MSK_NIBBLE    = 8'h0F;
  localparam logic [7:0]  MSK_CTRL      = 8'h0F;
  // ----------------------------------------------------------------
  // figures
  // ----------------------------------------------------------------
  localparam int          CLK_HZ        = 50_000_000;
  localparam int          DAMP_BASE_US  = 250;
  localparam int          DAMP_BASE_CYC = DAMP_BASE_US * (CLK_HZ / 1_000_000);
  localparam int          STEP_MS       = 8;
  localparam int          STEP_CYC      = STEP_MS * (CLK_HZ / 1000);
  localparam logic [3:0]  TAIL_64MS     = 4'h7;
  localparam logic [13:0] FULL_ALAW     = 14'h1F80;
  localparam logic [13:0] FULL_MULAW    = 14'h1F5F;
  localparam logic [9:0]  TURBO_BASE    = 10'h15F;
  localparam logic [11:0] NV_LIM_64     = 12'h200;
  localparam logic [11:0] NV_LIM_128    = 12'h400;
  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] ramp_up_rate_sel;
    logic [2:0] ramp_down_rate_sel;
    logic [1:0] offset_magnitude_sel;
  } efa_saw_t;
  typedef struct packed {
    logic       slowdown_effect_sel;
    logic [4:0] slowdown_count_threshold;
    logic [1:0] large_coeff_threshold_sel;
  } efa_aux_t;
  typedef struct packed {
    logic       silence_active;
    logic       fast_adapt_active;
    logic       slowdown_active;
    logic       update_limit_one;
  } efa_state_t;
endpackage

// File: hdl/efa_cfg.sv
// echo filter adaptation configuration bank with derived control logic
// Operation
// - receive bit phase selects phase 0..3
// - offset or saw-tooth added for stability
// - both rates zero stops saw-tooth clock
// - add value to linearised receive samples
// - damping period is 250 us times 2^n
// - no damping while coefficients are frozen
// - echo tail is (code+1) times 8 ms
// - without 128 ms mode clamp to 64 ms
// - tandem: master/slave own alternate channel quads
// - peak window is (code+1) times 8 ms
// - check window uses same 8 ms coding
// - hang-over (code+1) times 8 ms, hysteresis only
// - qualifying level within margin times 3 dB
// - no-voice when count reaches 512 or 1024
// - counter preset is field times 2 or 4
// - turbo when coefficient exceeds 351 plus 4*threshold
// - slow-down when 8*count threshold coefficients large
// - slow-down effect: no turbo, step one
// - large threshold is turbo minus 32/16/8/0
// - hysteresis holds no-voice for hang-over time
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module efa_cfg #(
  parameter int          STEP_CYCLES  = efa_pkg::STEP_CYC,
  parameter int          DAMP_CYCLES  = efa_pkg::DAMP_BASE_CYC,
  parameter int          SAW_DIV_BASE = 64,
  parameter logic [13:0] AMP_0        = 14'h0010,
  parameter logic [13:0] AMP_1        = 14'h0020,
  parameter logic [13:0] AMP_2        = 14'h0040,
  parameter logic [13:0] AMP_3        = 14'h0080
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        op_mode_pin_lo,
  input  wire logic        op_mode_pin_hi,
  input  wire logic        coeff_frozen,
  input  wire logic        alaw_sel,
  input  wire logic [13:0] rx_lin_sample,
  input  wire logic        rx_lin_valid,
  output logic      [14:0] rx_filter_in,
  input  wire logic [4:0]  rx_channel,
  output logic             channel_owned,
  input  wire logic [9:0]  aux_coeff_mag,
  input  wire logic        aux_coeff_valid,
  input  wire logic        aux_sweep_end,
  input  wire logic        rx_qualify_level,
  output logic      [1:0]  rx_in_bit_phase_sel,
  output logic      [3:0]  silence_level_margin,
  output logic             silence_hysteresis_en,
  output logic             main_damp_tick,
  output logic             aux_damp_tick,
  output logic      [3:0]  tail_eff_code,
  output logic      [9:0]  large_coeff_level,
  output efa_pkg::efa_state_t state_out
);
  // ----------------------------------------------------------------
  // register bank
  // ----------------------------------------------------------------
  logic [7:0] saw_ff, damp_ff, tail_ff, win_ff, hang_ff, preset_ff, turbo_ff, aux_ff, ctrl_ff;
  logic       acc_w;
  logic       mode128;
  efa_pkg::efa_saw_t saw;
  efa_pkg::efa_aux_t aux;
  assign acc_w   = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign mode128 = op_mode_pin_hi;
  assign saw     = efa_pkg::efa_saw_t'(saw_ff);
  assign aux     = efa_pkg::efa_aux_t'(aux_ff);
  assign rx_in_bit_phase_sel   = ctrl_ff[1:0];
  assign silence_hysteresis_en = ctrl_ff[2];
  assign silence_level_margin  = hang_ff[3:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      saw_ff    <= efa_pkg::RST_SAWTOOTH;
      damp_ff   <= efa_pkg::RST_DAMPING;
      tail_ff   <= efa_pkg::RST_TAIL;
      win_ff    <= efa_pkg::RST_WINDOWS;
      hang_ff   <= efa_pkg::RST_HANG_GAP;
      preset_ff <= efa_pkg::RST_PRESET;
      turbo_ff  <= efa_pkg::RST_TURBO;
      aux_ff    <= efa_pkg::RST_AUXSUP;
      ctrl_ff   <= efa_pkg::RST_CTRL;
    end else if (acc_w) begin
      case (paddr)
        efa_pkg::OFF_SAWTOOTH: saw_ff    <= pwdata[7:0];
        efa_pkg::OFF_DAMPING:  damp_ff   <= pwdata[7:0] & efa_pkg::MSK_DAMPING;
        efa_pkg::OFF_TAIL:     tail_ff   <= pwdata[7:0] & efa_pkg::MSK_NIBBLE;
        efa_pkg::OFF_WINDOWS:  win_ff    <= pwdata[7:0];
        efa_pkg::OFF_HANG_GAP: hang_ff   <= pwdata[7:0];
        efa_pkg::OFF_PRESET:   preset_ff <= pwdata[7:0];
        efa_pkg::OFF_TURBO:    turbo_ff  <= pwdata[7:0] & efa_pkg::MSK_NIBBLE;
        efa_pkg::OFF_AUXSUP:   aux_ff    <= pwdata[7:0];
        efa_pkg::OFF_CTRL:     ctrl_ff   <= pwdata[7:0] & efa_pkg::MSK_CTRL;
        default: ;
      endcase
    end
  end

  // unmapped addresses answer with an error, reads of them return zero
  always_comb begin
    prdata  = 32'h0000_0000;
    pslverr = 1'b0;
    case (paddr)
      efa_pkg::OFF_SAWTOOTH: prdata[7:0] = saw_ff;
      efa_pkg::OFF_DAMPING:  prdata[7:0] = damp_ff;
      efa_pkg::OFF_TAIL:     prdata[7:0] = tail_ff;
      efa_pkg::OFF_WINDOWS:  prdata[7:0] = win_ff;
      efa_pkg::OFF_HANG_GAP: prdata[7:0] = hang_ff;
      efa_pkg::OFF_PRESET:   prdata[7:0] = preset_ff;
      efa_pkg::OFF_TURBO:    prdata[7:0] = turbo_ff;
      efa_pkg::OFF_AUXSUP:   prdata[7:0] = aux_ff;
      efa_pkg::OFF_CTRL:     prdata[7:0] = ctrl_ff;
      efa_pkg::OFF_STATUS:   prdata[3:0] = state_out;
      default:               pslverr     = psel && penable;
    endcase
  end

  // ----------------------------------------------------------------
  // spring damping timers
  // ----------------------------------------------------------------
  logic [22:0] main_cnt_ff, aux_cnt_ff;
  logic [22:0] main_per, aux_per;
  assign main_per = 23'(DAMP_CYCLES) << damp_ff[2:0];
  assign aux_per  = 23'(DAMP_CYCLES) << damp_ff[6:4];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_cnt_ff    <= '0;
      aux_cnt_ff     <= '0;
      main_damp_tick <= 1'b0;
      aux_damp_tick  <= 1'b0;
    end else if (coeff_frozen) begin
      main_cnt_ff    <= '0;
      aux_cnt_ff     <= '0;
      main_damp_tick <= 1'b0;
      aux_damp_tick  <= 1'b0;
    end else begin
      main_damp_tick <= main_cnt_ff >= main_per - 23'd1;
      aux_damp_tick  <= aux_cnt_ff >= aux_per - 23'd1;
      main_cnt_ff    <= (main_cnt_ff >= main_per - 23'd1) ? '0 : main_cnt_ff + 23'd1;
      aux_cnt_ff     <= (aux_cnt_ff >= aux_per - 23'd1) ? '0 : aux_cnt_ff + 23'd1;
    end
  end

  // ----------------------------------------------------------------
  // saw-tooth and offset generator
  // ----------------------------------------------------------------
  logic [13:0] amp;
  logic [13:0] saw_lvl_ff;
  logic        saw_dir_ff;
  logic [15:0] saw_div_ff;
  logic [2:0]  cur_rate;
  logic        saw_run;
  logic [14:0] sum;
  logic [13:0] full;
  always_comb begin
    case (saw.offset_magnitude_sel)
      2'h0:    amp = AMP_0;
      2'h1:    amp = AMP_1;
      2'h2:    amp = AMP_2;
      default: amp = AMP_3;
    endcase
  end
  // each rate code step doubles the clock frequency
  assign cur_rate = saw_dir_ff ? saw.ramp_down_rate_sel : saw.ramp_up_rate_sel;
  assign saw_run  = (saw.ramp_up_rate_sel != 3'h0) || (saw.ramp_down_rate_sel != 3'h0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      saw_lvl_ff <= '0;
      saw_dir_ff <= 1'b0;
      saw_div_ff <= '0;
    end else if (!saw_run) begin
      saw_lvl_ff <= amp;
      saw_dir_ff <= 1'b0;
      saw_div_ff <= '0;
    end else if (saw_div_ff >= (16'(SAW_DIV_BASE) << (3'h7 - cur_rate))) begin
      saw_div_ff <= '0;
      if (cur_rate != 3'h0) begin
        if (!saw_dir_ff) begin
          saw_lvl_ff <= (saw_lvl_ff >= amp) ? amp : saw_lvl_ff + 14'd1;
          saw_dir_ff <= saw_lvl_ff >= amp;
        end else begin
          saw_lvl_ff <= (saw_lvl_ff == 14'd0) ? 14'd0 : saw_lvl_ff - 14'd1;
          saw_dir_ff <= saw_lvl_ff != 14'd0;
        end
      end else begin
        saw_dir_ff <= ~saw_dir_ff;
      end
    end else begin
      saw_div_ff <= saw_div_ff + 16'd1;
    end
  end

  // saturate at the coding's full scale so the filter never sees wrap-around
  assign full = alaw_sel ? efa_pkg::FULL_ALAW : efa_pkg::FULL_MULAW;
  assign sum  = {1'b0, rx_lin_sample} + {1'b0, saw_lvl_ff};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_filter_in <= '0;
    end else if (rx_lin_valid) begin
      rx_filter_in <= (sum > {1'b0, full}) ? {1'b0, full} : sum;
    end
  end

  // ----------------------------------------------------------------
  // tail delay and channel split
  // ----------------------------------------------------------------
  assign tail_eff_code = (!mode128 && tail_ff[3:0] > efa_pkg::TAIL_64MS) ?
                         efa_pkg::TAIL_64MS : tail_ff[3:0];
  // op_mode_pin_lo high marks the slave of a tandem pair
  assign channel_owned = !mode128 || (rx_channel[2] == op_mode_pin_lo);

  // ----------------------------------------------------------------
  // no-voice detection
  // ----------------------------------------------------------------
  logic [26:0] win_cnt_ff, peak_cnt_ff, hang_cnt_ff;
  logic [11:0] nv_cnt_ff;
  logic        nv_ff;
  logic        win_end, peak_end;
  logic [11:0] nv_init;
  logic [11:0] nv_lim;
  assign win_end  = win_cnt_ff >= 27'(STEP_CYCLES) * ({23'd0, win_ff[3:0]} + 27'd1) - 27'd1;
  assign peak_end = peak_cnt_ff >= 27'(STEP_CYCLES) * ({23'd0, win_ff[7:4]} + 27'd1) - 27'd1;
  assign nv_init  = mode128 ? {2'b00, preset_ff, 2'b00} : {3'b000, preset_ff, 1'b0};
  assign nv_lim   = mode128 ? efa_pkg::NV_LIM_128 : efa_pkg::NV_LIM_64;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peak_cnt_ff <= '0;
    end else begin
      peak_cnt_ff <= peak_end ? '0 : peak_cnt_ff + 27'd1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_cnt_ff  <= '0;
      nv_cnt_ff   <= '0;
      nv_ff       <= 1'b0;
      hang_cnt_ff <= '0;
    end else if (win_end) begin
      win_cnt_ff <= '0;
      nv_cnt_ff  <= nv_init;
      if (nv_cnt_ff >= nv_lim) begin
        nv_ff       <= 1'b1;
        hang_cnt_ff <= 27'(STEP_CYCLES) * ({23'd0, hang_ff[7:4]} + 27'd1);
      end else if (!silence_hysteresis_en || hang_cnt_ff == '0) begin
        nv_ff <= 1'b0;
      end else begin
        hang_cnt_ff <= hang_cnt_ff - 27'd1;
      end
    end else begin
      win_cnt_ff <= win_cnt_ff + 27'd1;
      if (rx_lin_valid && rx_qualify_level && nv_cnt_ff != 12'hFFF) begin
        nv_cnt_ff <= nv_cnt_ff + 12'd1;
      end
      if (silence_hysteresis_en && hang_cnt_ff != '0) begin
        hang_cnt_ff <= hang_cnt_ff - 27'd1;
      end else if (silence_hysteresis_en && nv_ff && hang_cnt_ff == '0) begin
        nv_ff <= nv_cnt_ff >= nv_lim;
      end
    end
  end

  // ----------------------------------------------------------------
  // turbo and slow-down supervision
  // ----------------------------------------------------------------
  logic [9:0] turbo_lvl;
  logic [7:0] large_cnt_ff;
  logic       turbo_hit_ff, slow_ff;
  assign turbo_lvl = efa_pkg::TURBO_BASE + {4'h0, turbo_ff[3:0], 2'b00};
  always_comb begin
    case (aux.large_coeff_threshold_sel)
      2'h0:    large_coeff_level = turbo_lvl - 10'd32;
      2'h1:    large_coeff_level = turbo_lvl - 10'd16;
      2'h2:    large_coeff_level = turbo_lvl - 10'd8;
      default: large_coeff_level = turbo_lvl;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      large_cnt_ff <= '0;
      turbo_hit_ff <= 1'b0;
      slow_ff      <= 1'b0;
    end else if (aux_sweep_end) begin
      large_cnt_ff <= '0;
      turbo_hit_ff <= 1'b0;
      // zero threshold switches slow-down supervision off
      slow_ff      <= (aux.slowdown_count_threshold != 5'h0) &&
                      (large_cnt_ff >= {aux.slowdown_count_threshold, 3'b000});
    end else if (aux_coeff_valid) begin
      if (aux_coeff_mag > large_coeff_level && large_cnt_ff != 8'hFF) begin
        large_cnt_ff <= large_cnt_ff + 8'd1;
      end
      if (aux_coeff_mag > turbo_lvl) begin
        turbo_hit_ff <= 1'b1;
      end
    end
  end

  // turbo is taken from the sweep just completed, held until the next sweep ends
  logic turbo_ff_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      turbo_ff_q <= 1'b0;
    end else if (aux_sweep_end) begin
      turbo_ff_q <= turbo_hit_ff;
    end
  end

  assign state_out.silence_active    = nv_ff;
  assign state_out.slowdown_active   = slow_ff;
  assign state_out.fast_adapt_active = turbo_ff_q && !(slow_ff && aux.slowdown_effect_sel);
  assign state_out.update_limit_one  = slow_ff && aux.slowdown_effect_sel;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_tail_clamp: assert property (@(posedge pclk) disable iff (!presetn)
    !mode128 |-> tail_eff_code <= efa_pkg::TAIL_64MS)
    else $error("tail not clamped to 64 ms");
  a_turbo_block: assert property (@(posedge pclk) disable iff (!presetn)
    (slow_ff && aux.slowdown_effect_sel) |-> !state_out.fast_adapt_active)
    else $error("turbo active during slow-down");
  a_frozen_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    coeff_frozen |=> !main_damp_tick && !aux_damp_tick)
    else $error("damping tick while frozen");
  a_saw_const: assert property (@(posedge pclk) disable iff (!presetn)
    !saw_run |=> saw_lvl_ff == $past(amp))
    else $error("offset not constant");
  a_preset_load: assert property (@(posedge pclk) disable iff (!presetn)
    win_end |=> nv_cnt_ff == $past(nv_init))
    else $error("no-voice counter not preset");
  a_nv_declare: assert property (@(posedge pclk) disable iff (!presetn)
    (win_end && nv_cnt_ff >= nv_lim) |=> nv_ff)
    else $error("no-voice not declared");
  a_large_level: assert property (@(posedge pclk) disable iff (!presetn)
    aux.large_coeff_threshold_sel == 2'h0 |-> large_coeff_level == turbo_lvl - 10'd32)
    else $error("large level wrong");
  a_owned_split: assert property (@(posedge pclk) disable iff (!presetn)
    (mode128 && !op_mode_pin_lo && rx_channel[2]) |-> !channel_owned)
    else $error("master owns slave channel");
endmodule
`default_nettype wire

// File: testbench/testbench.sv
// self-checking bench for the echo filter adaptation configuration bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct {string nm; int src; logic [31:0] exp;} efa_note_t;
  localparam logic [13:0] AMPS [4] = '{14'h0011, 14'h0022, 14'h0044, 14'h0088};
  localparam logic [11:0] ADR [8] = '{efa_pkg::OFF_SAWTOOTH, efa_pkg::OFF_DAMPING,
    efa_pkg::OFF_TAIL, efa_pkg::OFF_WINDOWS, efa_pkg::OFF_HANG_GAP, efa_pkg::OFF_PRESET,
    efa_pkg::OFF_TURBO, efa_pkg::OFF_AUXSUP};
  localparam logic [7:0]  RST [8] = '{efa_pkg::RST_SAWTOOTH, efa_pkg::RST_DAMPING,
    efa_pkg::RST_TAIL, efa_pkg::RST_WINDOWS, efa_pkg::RST_HANG_GAP, efa_pkg::RST_PRESET,
    efa_pkg::RST_TURBO, efa_pkg::RST_AUXSUP};
  localparam logic [7:0]  MSK [8] = '{8'hFF, efa_pkg::MSK_DAMPING, efa_pkg::MSK_NIBBLE,
    8'hFF, 8'hFF, 8'hFF, efa_pkg::MSK_NIBBLE, 8'hFF};
  localparam int          DEC [4] = '{32, 16, 8, 0};
  logic        pclk = 1'b0, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, obs, seen, d;
  logic        op_mode_pin_lo, op_mode_pin_hi, coeff_frozen, alaw_sel, rx_lin_valid;
  logic [13:0] rx_lin_sample;
  logic [14:0] rx_filter_in;
  logic [4:0]  rx_channel;
  logic        channel_owned, aux_coeff_valid, aux_sweep_end, rx_qualify_level;
  logic [9:0]  aux_coeff_mag, large_coeff_level;
  logic [1:0]  rx_in_bit_phase_sel;
  logic [3:0]  silence_level_margin, tail_eff_code;
  logic        silence_hysteresis_en, main_damp_tick, aux_damp_tick;
  efa_pkg::efa_state_t state_out;
  efa_note_t   q [$];
  efa_note_t   nt;
  int          err_count = 0, n_tests = 0, th, p, k;
  always #10 pclk = ~pclk;
  efa_cfg #(.STEP_CYCLES(20), .DAMP_CYCLES(4), .AMP_0(AMPS[0]), .AMP_1(AMPS[1]),
    .AMP_2(AMPS[2]), .AMP_3(AMPS[3])) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .op_mode_pin_lo(op_mode_pin_lo),
    .op_mode_pin_hi(op_mode_pin_hi), .coeff_frozen(coeff_frozen), .alaw_sel(alaw_sel),
    .rx_lin_sample(rx_lin_sample), .rx_lin_valid(rx_lin_valid),
    .rx_filter_in(rx_filter_in), .rx_channel(rx_channel), .channel_owned(channel_owned),
    .aux_coeff_mag(aux_coeff_mag), .aux_coeff_valid(aux_coeff_valid),
    .aux_sweep_end(aux_sweep_end), .rx_qualify_level(rx_qualify_level),
    .rx_in_bit_phase_sel(rx_in_bit_phase_sel), .silence_level_margin(silence_level_margin),
    .silence_hysteresis_en(silence_hysteresis_en), .main_damp_tick(main_damp_tick),
    .aux_damp_tick(aux_damp_tick), .tail_eff_code(tail_eff_code),
    .large_coeff_level(large_coeff_level), .state_out(state_out));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic note(input string nm, input int src, input logic [31:0] e);
    q.push_back('{nm, src, e});
    @(posedge pclk);
  endtask
  // apb: obs gets read data, or the error flag for a write
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // wait for pready; the bank ties it high, so this ends after one cycle
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    obs = w ? {31'h0, pslverr} : prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic sweep(input logic [9:0] m, input int c);
    repeat (c) begin
      aux_coeff_mag   <= m;
      aux_coeff_valid <= 1'b1;
      @(posedge pclk);
      aux_coeff_valid <= 1'b0;
      @(posedge pclk);
    end
    aux_sweep_end <= 1'b1;
    @(posedge pclk);
    aux_sweep_end <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  // first pass only finds a tick; the last two give whole periods after a reload
  task automatic period(input logic a, output int pp);
    for (int i = 0; i < 3; i++) begin
      pp = 0;
      do begin
        @(negedge pclk);
        pp++;
      end while ((a ? aux_damp_tick : main_damp_tick) !== 1'b1 && pp < 3000);
    end
    @(posedge pclk);
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // output watcher
  // ----------------------------------------------------------------
  always @(negedge pclk) begin
    if (q.size() > 0) begin
      nt = q.pop_front();
      case (nt.src)
        1: seen = 32'(tail_eff_code);
        2: seen = 32'(channel_owned);
        3: seen = 32'(large_coeff_level);
        4: seen = 32'(rx_in_bit_phase_sel);
        5: seen = 32'(silence_level_margin);
        6: seen = 32'(silence_hysteresis_en);
        7: seen = 32'(state_out);
        8: seen = 32'(state_out[1:0]);
        9: seen = 32'(rx_filter_in);
        10: seen = 32'(state_out.silence_active);
        default: seen = obs;
      endcase
      check(nt.nm, seen, nt.exp);
    end
  end
  initial begin
    repeat (40000) @(posedge pclk);
    err_count++;
    test_done();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {op_mode_pin_lo, op_mode_pin_hi, coeff_frozen, alaw_sel} = 4'h0;
    {rx_lin_sample, rx_lin_valid, rx_channel, rx_qualify_level} = '0;
    {aux_coeff_mag, aux_coeff_valid, aux_sweep_end} = '0;
    void'($urandom(75340));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, ADR[i], 32'h0);
      note("reset value", 0, 32'(RST[i]));
    end
    note("tail after reset", 1, 32'h7);
    for (int i = 0; i < 8; i++) begin
      d = $urandom;
      apb(1'b1, ADR[i], d);
      apb(1'b0, ADR[i], 32'h0);
      note("read back", 0, 32'(d[7:0] & MSK[i]));
    end
    apb(1'b1, 12'h1D8, $urandom);
    note("unmapped error", 0, 32'h1);
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, efa_pkg::OFF_CTRL, 32'(i));
      note("bit phase", 4, 32'(i % 4));
      note("hysteresis", 6, 32'(i / 4));
      d = $urandom;
      apb(1'b1, efa_pkg::OFF_HANG_GAP, d);
      note("margin", 5, 32'(d[3:0]));
    end
    for (int m = 0; m < 2; m++) begin
      op_mode_pin_hi <= m[0];
      for (int c = 0; c < 16; c++) begin
        apb(1'b1, efa_pkg::OFF_TAIL, 32'(c));
        note("tail code", 1, (m == 1 || c < 7) ? 32'(c) : 32'h7);
      end
    end
    for (int r = 0; r < 2; r++) begin
      op_mode_pin_lo <= r[0];
      for (int ch = 0; ch < 32; ch++) begin
        rx_channel <= 5'(ch);
        @(posedge pclk);
        note("channel owned", 2, 32'((ch / 4) % 2 == r));
      end
    end
    $display("test modes done");
    for (int s = 0; s < 4; s++) begin
      th = $urandom % 16;
      apb(1'b1, efa_pkg::OFF_TURBO, 32'(th));
      apb(1'b1, efa_pkg::OFF_AUXSUP, 32'(s));
      note("large level", 3, 32'(efa_pkg::TURBO_BASE) + 4 * th - DEC[s]);
    end
    th = 351 + 4 * ($urandom % 16);
    apb(1'b1, efa_pkg::OFF_TURBO, 32'((th - 351) / 4));
    apb(1'b1, efa_pkg::OFF_AUXSUP, 32'h0);
    sweep(10'(th + 1), 1);
    note("turbo above", 7, 32'h4);
    sweep(10'(th), 1);
    note("turbo at limit", 7, 32'h0);
    apb(1'b1, efa_pkg::OFF_AUXSUP, 32'h87);
    sweep(10'(th + 1), 8);
    note("slowdown limit", 7, 32'h3);
    sweep(10'(th + 1), 7);
    note("slowdown short", 7, 32'h4);
    apb(1'b1, efa_pkg::OFF_AUXSUP, 32'h07);
    sweep(10'(th + 1), 8);
    note("slowdown normal", 8, 32'h2);
    $display("test coefficients done");
    for (int n = 0; n < 8; n++) begin
      // different codes per field so a swapped field shows up
      apb(1'b1, efa_pkg::OFF_DAMPING, 32'(n | ((7 - n) << 4)));
      period(1'b0, p);
      obs = 32'(p);
      note("main period", 0, 32'(4 << n));
      period(1'b1, p);
      obs = 32'(p);
      note("aux period", 0, 32'(4 << (7 - n)));
    end
    apb(1'b1, efa_pkg::OFF_DAMPING, 32'h0);
    coeff_frozen <= 1'b1;
    repeat (2) @(posedge pclk);
    k = 0;
    repeat (300) begin
      @(negedge pclk);
      if (main_damp_tick === 1'b1 || aux_damp_tick === 1'b1) k++;
    end
    @(posedge pclk);
    obs = 32'(k);
    note("frozen ticks", 0, 32'h0);
    coeff_frozen <= 1'b0;
    $display("test damping done");
    for (int a = 0; a < 4; a++) begin
      apb(1'b1, efa_pkg::OFF_SAWTOOTH, 32'(a));
      d = $urandom % 4096;
      rx_lin_sample <= d[13:0];
      rx_lin_valid  <= 1'b1;
      @(posedge pclk);
      rx_lin_valid  <= 1'b0;
      @(posedge pclk);
      note("offset sum", 9, d + 32'(AMPS[a]));
    end
    for (int l = 0; l < 2; l++) begin
      alaw_sel      <= l[0];
      rx_lin_sample <= 14'h3FFF;
      rx_lin_valid  <= 1'b1;
      @(posedge pclk);
      rx_lin_valid  <= 1'b0;
      @(posedge pclk);
      note("saturation", 9, l ? 32'(efa_pkg::FULL_ALAW) : 32'(efa_pkg::FULL_MULAW));
    end
    $display("test offset done");
    // 20-cycle windows; preset near the limit so a full window of hits declares
    apb(1'b1, efa_pkg::OFF_WINDOWS, 32'h0);
    apb(1'b1, efa_pkg::OFF_PRESET, 32'hFF);
    apb(1'b1, efa_pkg::OFF_HANG_GAP, 32'hF0);
    for (int h = 0; h < 2; h++) begin
      apb(1'b1, efa_pkg::OFF_CTRL, 32'(4 * h));
      rx_qualify_level <= 1'b1;
      rx_lin_valid     <= 1'b1;
      repeat (50) @(posedge pclk);
      note("no-voice on", 10, 32'h1);
      apb(1'b0, efa_pkg::OFF_STATUS, 32'h0);
      note("status", 0, 32'hE);
      rx_qualify_level <= 1'b0;
      repeat (50) @(posedge pclk);
      note("no-voice hold", 10, 32'(h));
      repeat (400) @(posedge pclk);
      note("no-voice off", 10, 32'h0);
    end
    rx_lin_valid <= 1'b0;
    $display("test no-voice done");
    repeat (4) @(posedge pclk);
    test_done();
  end
endmodule
`default_nettype wire
